// ===== src/stcm_map.vh
// register map, field positions and timing counts of the serial transceiver control master
`ifndef STCM_MAP_VH
`define STCM_MAP_VH
`define STCM_OFF_CTRL 12'h000
`define STCM_OFF_CMD 12'h004
`define STCM_OFF_STAT 12'h008
`define STCM_OFF_RDATA 12'h00c
`define STCM_OFF_DIV 12'h010
`define STCM_CTRL_GO 0
`define STCM_CTRL_INIT 1
`define STCM_CTRL_READ 2
`define STCM_CTRL_EXT 3
`define STCM_CMD_ADDR_LSB 0
`define STCM_CMD_INDEX_LSB 8
`define STCM_CMD_EXT_LSB 16
`define STCM_CMD_DATA_LSB 24
`define STCM_STAT_BUSY 0
`define STCM_STAT_DONE 1
`define STCM_STAT_IDX_ERR 2
`define STCM_INDEX_EXT 4'hf
`define STCM_INIT_CYCLES 8'd30
`define STCM_END_LOW 8'd1
`define STCM_END_TAIL 8'd3
`define STCM_RESP_BITS 8'd8
`define STCM_DIV_RESET 8'h04
`define STCM_QUAL_WRITE 1'b1
`define STCM_QUAL_READ 1'b0
`endif

// ===== src/stcm_clkgen.v
// serial clock divider: half period counter with rise and fall pulses
`timescale 1ns/10ps
module stcm_clkgen #(
  parameter W = 8
) (
  input wire sys_clk,
  input wire rst_n,
  input wire run,
  input wire [W-1:0] half_div,
  output reg sclk_r,
  output wire rise,
  output wire fall
);
  reg [W-1:0] cnt_r;
  wire tick;
  // divider stops with the clock low, so the line is idle between transactions
  assign tick = run && (cnt_r >= half_div);
  assign rise = tick && !sclk_r;
  assign fall = tick && sclk_r;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {W{1'b0}};
      sclk_r <= 1'b0;
    end else if (!run) begin
      cnt_r <= {W{1'b0}};
      sclk_r <= 1'b0;
    end else if (tick) begin
      cnt_r <= {W{1'b0}};
      sclk_r <= ~sclk_r;
    end else begin
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule // stcm_clkgen

// ===== src/stcm_master.v
// serial transceiver control master with apb register port
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "stcm_map.vh"
module stcm_master #(
  parameter DIVW = 8
) (
  input wire sys_clk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire sclk,
  output reg write_serial_line,
  input wire read_serial_line
);
  localparam S_IDLE = 3'd0;
  localparam S_PEND = 3'd1;
  localparam S_START = 3'd2;
  localparam S_BITS = 3'd3;
  localparam S_TAIL = 3'd4;
  localparam S_RESP = 3'd5;
  localparam S_INIT = 3'd6;
  localparam S_LAST = 3'd7;
  reg rst_m_r, rst_s_r;
  wire rst_n;
  reg [3:0] ctrl_r;
  reg [31:0] cmd_r;
  reg [DIVW-1:0] div_r;
  reg busy_r, done_r, idx_err_r;
  reg [7:0] rdata_r;
  reg [2:0] st_r;
  reg [23:0] sh_r;
  reg [1:0] nbytes_r, bytei_r;
  reg [2:0] biti_r;
  reg [7:0] cnt_r;
  reg [7:0] resp_r;
  reg rd_m_r, rd_s_r;
  reg rd_op_r;
  wire run, rise, fall;
  wire wr_acc, rd_acc;
  wire is_ext;
  wire [7:0] byte0;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end
  assign rst_n = rst_s_r;
  // apb slave: zero wait states, unmapped reads return zero
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  always @* begin
    case (paddr)
      `STCM_OFF_CTRL: prdata = {28'h0000000, ctrl_r};
      `STCM_OFF_CMD: prdata = cmd_r;
      `STCM_OFF_STAT: prdata = {29'h0000000, idx_err_r, done_r, busy_r};
      `STCM_OFF_RDATA: prdata = {24'h000000, rdata_r};
      `STCM_OFF_DIV: prdata = {{(32-DIVW){1'b0}}, div_r};
      default: prdata = 32'h00000000;
    endcase
  end
  // sampled read line passes two flops before use
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_m_r <= 1'b0;
      rd_s_r <= 1'b0;
    end else begin
      rd_m_r <= read_serial_line;
      rd_s_r <= rd_m_r;
    end
  end
  assign is_ext = (cmd_r[`STCM_CMD_INDEX_LSB+3:`STCM_CMD_INDEX_LSB] == `STCM_INDEX_EXT);
  // first byte: address low, index middle, qualifier top
  assign byte0 = {ctrl_r[`STCM_CTRL_READ] ? `STCM_QUAL_READ : `STCM_QUAL_WRITE,
                  cmd_r[`STCM_CMD_INDEX_LSB+3:`STCM_CMD_INDEX_LSB],
                  cmd_r[`STCM_CMD_ADDR_LSB+2:`STCM_CMD_ADDR_LSB]};
  assign run = (st_r != S_IDLE);
  stcm_clkgen #(.W(DIVW)) u_clk (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(run),
    .half_div(div_r),
    .sclk_r(sclk),
    .rise(rise),
    .fall(fall)
  );
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= 4'h0;
      cmd_r <= 32'h00000000;
      div_r <= `STCM_DIV_RESET;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      idx_err_r <= 1'b0;
      rdata_r <= 8'h00;
      st_r <= S_IDLE;
      sh_r <= 24'h000000;
      nbytes_r <= 2'd0;
      bytei_r <= 2'd0;
      biti_r <= 3'd0;
      cnt_r <= 8'h00;
      resp_r <= 8'h00;
      rd_op_r <= 1'b0;
      write_serial_line <= 1'b0;
    end else begin
      if (wr_acc && paddr == `STCM_OFF_CTRL)
        ctrl_r <= {pwdata[3:2], 2'b00};
      if (wr_acc && paddr == `STCM_OFF_CMD && !busy_r)
        cmd_r <= pwdata;
      if (wr_acc && paddr == `STCM_OFF_DIV && !busy_r && pwdata[DIVW-1:0] != {DIVW{1'b0}})
        div_r <= pwdata[DIVW-1:0];
      // write-one-to-clear done; completion in the same cycle wins
      if (wr_acc && paddr == `STCM_OFF_STAT && pwdata[`STCM_STAT_DONE])
        done_r <= 1'b0;
      if (wr_acc && paddr == `STCM_OFF_STAT && pwdata[`STCM_STAT_IDX_ERR])
        idx_err_r <= 1'b0;
      case (st_r)
        S_IDLE: begin
          write_serial_line <= 1'b0;
          if (wr_acc && paddr == `STCM_OFF_CTRL && !busy_r && pwdata[`STCM_CTRL_INIT]) begin
            busy_r <= 1'b1;
            cnt_r <= 8'h00;
            st_r <= S_INIT;
          end else if (wr_acc && paddr == `STCM_OFF_CTRL && !busy_r && pwdata[`STCM_CTRL_GO]) begin
            busy_r <= 1'b1;
            rd_op_r <= pwdata[`STCM_CTRL_READ];
            // extended index needs the ext flag to agree with the index pattern
            if (pwdata[`STCM_CTRL_EXT] != is_ext)
              idx_err_r <= 1'b1;
            st_r <= S_PEND;
          end
        end
        S_INIT: begin
          write_serial_line <= 1'b0;
          if (rise) begin
            cnt_r <= cnt_r + 8'h01;
            if (cnt_r == `STCM_INIT_CYCLES - 8'h01)
              st_r <= S_LAST;
          end
        end
        S_PEND: if (rise) begin
          // byte set up here: first, then extended index if any, then payload on writes
          if (ctrl_r[`STCM_CTRL_READ]) begin
            nbytes_r <= is_ext ? 2'd2 : 2'd1;
            sh_r <= {8'h00, cmd_r[`STCM_CMD_EXT_LSB+7:`STCM_CMD_EXT_LSB], byte0};
          end else if (is_ext) begin
            nbytes_r <= 2'd3;
            sh_r <= {cmd_r[`STCM_CMD_DATA_LSB+7:`STCM_CMD_DATA_LSB],
                     cmd_r[`STCM_CMD_EXT_LSB+7:`STCM_CMD_EXT_LSB], byte0};
          end else begin
            nbytes_r <= 2'd2;
            sh_r <= {8'h00, cmd_r[`STCM_CMD_DATA_LSB+7:`STCM_CMD_DATA_LSB], byte0};
          end
          bytei_r <= 2'd0;
          st_r <= S_START;
        end
        S_START: if (rise) begin
          // this rising edge is the start cycle of the byte
          biti_r <= 3'd0;
          st_r <= S_BITS;
        end else if (fall) begin
          write_serial_line <= 1'b0;
        end
        S_BITS: if (fall) begin
          write_serial_line <= sh_r[0];
        end else if (rise) begin
          sh_r <= {1'b0, sh_r[23:1]};
          biti_r <= biti_r + 3'd1;
          if (biti_r == 3'd7) begin
            bytei_r <= bytei_r + 2'd1;
            if (bytei_r + 2'd1 != nbytes_r)
              st_r <= S_START;
            else if (rd_op_r) begin
              cnt_r <= 8'h00;
              st_r <= S_TAIL;
            end else
              st_r <= S_LAST;
          end
        end
        S_TAIL: if (fall) begin
          // low one clock, then start plus eight response clocks
          write_serial_line <= 1'b0;
        end else if (rise) begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == `STCM_END_LOW) begin
            biti_r <= 3'd0;
            cnt_r <= 8'h00;
            st_r <= S_RESP;
          end
        end
        S_RESP: if (fall) begin
          // end marker: high then low across the last three clocks
          if (cnt_r == `STCM_RESP_BITS - `STCM_END_TAIL)
            write_serial_line <= 1'b1;
          else if (cnt_r == `STCM_RESP_BITS - `STCM_END_TAIL + 8'h02)
            write_serial_line <= 1'b0;
        end else if (rise) begin
          // synchroniser delay is short against the half period
          resp_r <= {rd_s_r, resp_r[7:1]};
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == `STCM_RESP_BITS - 8'h01) begin
            rdata_r <= {rd_s_r, resp_r[7:1]};
            st_r <= S_LAST;
          end
        end
        S_LAST: if (fall) begin
          // stop the clock low after the final cycle
          write_serial_line <= 1'b0;
          busy_r <= 1'b0;
          done_r <= 1'b1;
          st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
endmodule // stcm_master

// ===== testbench/stcm_master_properties.sv
// port checker for the serial control master
`timescale 1ns/10ps
module stcm_master_properties (
  input wire sys_clk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire sclk,
  input wire write_serial_line
);
  localparam int IDLE = 16;
  logic [7:0] lo, hi, rises;
  logic [3:0] hist;
  logic acc;
  wire fend = lo == IDLE;
  wire rose = sclk && hi == 8'h00;
  wire w = write_serial_line;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lo <= 8'h00;
      hi <= 8'h00;
      rises <= 8'h00;
      acc <= 1'b0;
    end else begin
      lo <= sclk ? 8'h00 : lo + {7'h00, lo != 8'hff};
      hi <= sclk ? hi + 8'h01 : 8'h00;
      rises <= fend ? 8'h00 : rises + {7'h00, rose};
      acc <= !fend && (acc || (rose && w));
    end
  end
  // no reset needed: only read once a full frame has filled it
  always @(posedge sys_clk) begin
    if (rose) begin
      hist <= {hist[2:0], w};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_high; sclk [*4] ##1 !sclk; endsequence
  property p_wr_low; $changed(w) |-> !sclk; endproperty
  a_wr_low: assert property (p_wr_low) else $error("data moved with clock high");
  property p_high; $rose(sclk) |-> s_high; endproperty
  a_high: assert property (p_high) else $error("clock high time wrong");
  property p_gap; $rose(sclk) |-> lo == 8'd4 || lo >= IDLE; endproperty
  a_gap: assert property (p_gap) else $error("clock gap inside frame");
  // no extra clock after the last bit: the final data clock ends the frame
  property p_len; fend |-> rises inside {0, 19, 20, 28, 29, 30}; endproperty
  a_len: assert property (p_len) else $error("frame length wrong");
  property p_go; psel && penable && pwrite && paddr == 12'h000 && |pwdata[1:0] && lo > IDLE
    |-> ##[1:20] $rose(sclk); endproperty
  a_go: assert property (p_go) else $error("no frame after start");
  property p_tail; fend && rises inside {20, 29} |-> hist == 4'b0110; endproperty
  a_tail: assert property (p_tail) else $error("read end pattern wrong");
  property p_init; fend && rises == 8'd30 |-> !acc; endproperty
  a_init: assert property (p_init) else $error("data high during init");
  property p_quiet; $rose(rst_b) |-> !sclk [*3]; endproperty
  a_quiet: assert property (p_quiet) else $error("clock active after reset");
endmodule // stcm_master_properties
bind stcm_master stcm_master_properties i_props (.sys_clk(sys_clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .sclk(sclk), .write_serial_line(write_serial_line));

// ===== testbench/stcm_xcvr_model.sv
// behavioural transceiver at the far end of the serial control bus
`timescale 1ns/10ps
module stcm_xcvr_model #(
  parameter logic [2:0] OWN_ADDR = 3'h0,
  parameter logic [7:0] LOW_RATE = 8'h00,
  parameter logic [7:0] EXT_VAL = 8'h5a // arbitrary value
) (
  input wire sys_clk,
  input wire sclk,
  input wire write_serial_line,
  output wire read_serial_line
);
  logic [7:0] regs [3] = '{8'h07, LOW_RATE, 8'hff};
  logic [23:0] sh;
  logic [7:0] resp;
  logic ready = 0, ones = 0, ans = 0, drv = 0, rbit = 0, junk = 0;
  int n = 0, k = 0, idle = 0, rs = 99;
  always @(posedge sclk) begin
    n = n + 1;
    ones = ones | write_serial_line;
    if (n > 2 && (n - 2) % 9 != 0 && k < 24) begin
      sh[k] = write_serial_line;
      k = k + 1;
    end
    if (n == 10) begin
      rs = (sh[6:3] == 4'hf) ? 21 : 12;
      resp = sh[6:3] == 4'hf ? EXT_VAL : sh[6:3] < 3 ? regs[sh[4:3]] : 8'h00;
      ans = ready && !sh[7] && sh[2:0] == OWN_ADDR;
    end
    if (ans && n >= rs && n < rs + 8) begin
      drv <= 1'b1;
      rbit <= resp[n - rs];
    end else begin
      drv <= 1'b0;
    end
  end
  // a released line toggles every system clock instead of holding the last driven bit
  always @(posedge sys_clk) begin
    junk <= ~junk;
    idle = sclk ? 0 : idle + 1;
    if (idle == 12) begin
      if (n >= 30 && !ones) ready = 1'b1;
      else if (ready && sh[7] && sh[2:0] == OWN_ADDR && n == 19 && sh[6:3] < 3)
        regs[sh[4:3]] = sh[15:8];
      n = 0;
      k = 0;
      ones = 0;
      ans = 0;
    end
  end
  assign read_serial_line = drv ? rbit : junk;
endmodule // stcm_xcvr_model

// ===== testbench/stcm_master_test.sv
// self-checking bench for the serial control master
`timescale 1ns/10ps
`include "stcm_map.vh"
module stcm_master_test;
  logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, st;
  wire pready, pslverr, sclk, write_serial_line, read_serial_line;
  int failures = 0, check_count = 0;
  logic [7:0] rf [3] = '{8'h07, 8'h00, 8'hff};
  logic [7:0] d;
  logic [2:0] ad;
  always #20 sys_clk = ~sys_clk;
  stcm_master i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk(sclk), .write_serial_line(write_serial_line),
    .read_serial_line(read_serial_line));
  stcm_xcvr_model i_xcvr (.sys_clk(sys_clk), .sclk(sclk),
    .write_serial_line(write_serial_line), .read_serial_line(read_serial_line));
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge sys_clk);
    penable <= 1'b1;
    // request held until the edge that sees pready high; data taken at that edge
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    q = prdata;
    chk("pslverr", {31'h0, pslverr}, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask
  function automatic logic [31:0] cw(logic [2:0] a, logic [3:0] i, logic [7:0] e, logic [7:0] v);
    return {v, e, 4'h0, i, 5'h00, a};
  endfunction
  task automatic xfer(input logic [3:0] c, input logic [31:0] cmd);
    bus(1, `STCM_OFF_CMD, cmd);
    bus(1, `STCM_OFF_CTRL, {28'h0, c});
    q = 32'h1;
    while (q[0] !== 1'b0) bus(0, `STCM_OFF_STAT, 0);
    st = q;
    repeat (20) @(posedge sys_clk);
    bus(0, `STCM_OFF_RDATA, 0);
  endtask
  task automatic results;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    failures++;
    results;
  end
  initial begin
    void'($urandom(67));
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    bus(0, `STCM_OFF_DIV, 0);
    chk("div", q, 32'h4);
    bus(0, 12'h020, 0);
    chk("unmapped", q, 0);
    bus(1, `STCM_OFF_DIV, 3);
    xfer(4'h2, 0);
    chk("init done", st, 32'h2);
    bus(1, `STCM_OFF_STAT, 2);
    bus(0, `STCM_OFF_STAT, 0);
    chk("done clear", q, 0);
    $display("test reset and init done");
    for (int i = 0; i < 3; i++) begin
      xfer(4'h5, cw(0, i, 0, 0));
      chk("power-up value", q, rf[i]);
    end
    $display("test power-up values done");
    for (int i = 0; i < 3; i++) begin
      d = $urandom;
      rf[i] = d;
      xfer(4'h1, cw(0, i, $urandom, d));
      xfer(4'h5, cw(0, i, 0, 0));
      chk("readback", q, rf[i]);
    end
    $display("test write and read done");
    xfer(4'hd, cw(0, 4'hf, $urandom, 0));
    chk("ext read", q, i_xcvr.EXT_VAL);
    xfer(4'h9, cw(0, 4'hf, $urandom, $urandom));
    chk("ext write status", st, 32'h2);
    ad = 3'($urandom % 7) + 3'h1;
    xfer(4'h1, cw(ad, 1, 0, ~rf[1]));
    xfer(4'h5, cw(0, 1, 0, 0));
    chk("foreign address", q, rf[1]);
    xfer(4'hd, cw(0, 0, 0, 0));
    chk("index error", st & 32'h4, 32'h4);
    $display("test extended and address done");
    results;
  end
endmodule // stcm_master_test
